// ### rtl/filter_pkg.sv
// Purpose: shared constants for the reading smoothing filter
// Assumes: 24-bit unsigned readings, two sensor inputs, APB register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package filter_pkg;

	localparam int READ_W = 24;
	localparam int FRAC_W = 8;
	localparam int FILT_W = READ_W + FRAC_W;
	localparam int PTS_W = 7;
	localparam int WIN_W = 4;
	localparam int ADDR_W = 8;
	localparam int NUM_IN = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = READ_W + 1;
	localparam int DIV_STEPS = FILT_W;
	localparam int CNT_W = 6;

	localparam logic [7:0] PTS_MIN = 8'h02;
	localparam logic [7:0] PTS_MAX = 8'h40;
	localparam logic [7:0] PTS_DEF = 8'h08;
	localparam logic [7:0] WIN_MIN = 8'h01;
	localparam logic [7:0] WIN_MAX = 8'h0a;
	localparam logic [7:0] WIN_DEF = 8'h01;
	localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
	localparam logic [READ_W-1:0] FS_DEF = 24'hff_ffff;
	localparam logic [FRAC_W-1:0] FRAC_ZERO = 8'h00;

	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PTS_A = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PTS_B = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_WIN_A = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_WIN_B = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FS_A = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_FS_B = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DISP_A = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_DISP_B = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;

	localparam int BIT_EN_A = 0;
	localparam int BIT_EN_B = 1;
	localparam int BIT_ST_BUSY = 0;
	localparam int BIT_ST_PRIMED_A = 1;
	localparam int BIT_ST_PRIMED_B = 2;

	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_DIVIDE} filt_state_e;

endpackage

// ### rtl/reading_fifo.sv
// Purpose: small first-in first-out buffer for incoming readings
// Assumes: one clock, push and pop by valid/ready handshakes
// Notes: output word sits in a register, so one more word is held there
`timescale 1ns/1ps
module reading_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
)
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wptr_q;
	logic [PW-1:0] rptr_q;
	logic [PW:0] count_q;
	logic [PW:0] count_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = (count_q != '0) && (!out_valid || out_ready);
	assign count_d = count_q + (PW + 1)'(push) - (PW + 1)'(pop);

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_q[wptr_q] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			wptr_q <= push ? wptr_q + 1'b1 : wptr_q;
			rptr_q <= pop ? rptr_q + 1'b1 : rptr_q;
			count_q <= count_d;
			in_ready <= (count_d != FULL_CNT);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data <= mem_q[rptr_q];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end

endmodule

// ### rtl/point_divider.sv
// Purpose: unsigned serial divider for the smoothing weight
// Assumes: divisor never zero, start only while idle
// Notes: one quotient bit per clock, done pulses once at the end
`timescale 1ns/1ps
module point_divider
	import filter_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [FILT_W-1:0] dividend,
	input wire logic [PTS_W-1:0] divisor,
	output logic done,
	output logic [FILT_W-1:0] quotient
);
	logic [PTS_W:0] rem_q;
	logic [PTS_W:0] trial;
	logic [PTS_W-1:0] div_q;
	logic [CNT_W-1:0] cnt_q;
	logic busy_q;
	logic fit;

	assign trial = {rem_q[PTS_W-1:0], quotient[FILT_W-1]};
	assign fit = trial >= {1'b0, div_q};

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rem_q <= '0;
			div_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done <= 1'b0;
			quotient <= '0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				rem_q <= '0;
				div_q <= divisor;
				quotient <= dividend;
				cnt_q <= '0;
				busy_q <= 1'b1;
			end
			else if (busy_q)
			begin
				rem_q <= fit ? trial - {1'b0, div_q} : trial;
				quotient <= {quotient[FILT_W-2:0], fit};
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == CNT_W'(DIV_STEPS - 1))
				begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

// ### rtl/reading_smoothing_filter.sv
// Purpose: exponential smoothing of two sensor reading streams for display
// Assumes: readings arrive from same-clock front end logic with valid/ready
// Notes: registers on APB, zero wait states, filter keeps 8 fraction bits
//
// Overview of operation
// [RQ1] with filtering on, every reading of that input is smoothed, none skipped
// [RQ2] running average: one new filtered value for each new reading
// [RQ3] filtered values go to display output; control output gets raw readings
// [RQ4] each point is one reading; more points smooth more, respond slower
// [RQ5] point count per input is 2 to 64, 8 after reset
// [RQ6] restart when one reading differs from filtered value beyond window
// [RQ7] window is 1% to 10% of input full scale, 1% after reset
// [RQ8] independent enable per input; disabled input displays raw reading
// [RQ9] on restart, load filtered value with the reading, then smooth on
// [RQ10] filtered value moves by (reading minus filtered value) divided by N
`timescale 1ns/1ps
module reading_smoothing_filter
	import filter_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rd_valid,
	input wire logic rd_chan,
	input wire logic [READ_W-1:0] rd_data,
	output logic rd_ready,
	output logic ctrl_valid,
	output logic ctrl_chan,
	output logic [READ_W-1:0] ctrl_data,
	output logic disp_valid,
	output logic disp_chan,
	output logic [READ_W-1:0] disp_data,
	output logic disp_restart
);

	function automatic logic [7:0] clamp(input logic [31:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		logic [7:0] r;
		r = v[7:0];
		if (v < {24'h00_0000, lo})
			r = lo;
		else if (v > {24'h00_0000, hi})
			r = hi;
		return r;
	endfunction

	function automatic logic [READ_W-1:0] abs_sub(input logic [READ_W-1:0] a,
		input logic [READ_W-1:0] b);
		logic [READ_W-1:0] r;
		r = (a >= b) ? a - b : b - a;
		return r;
	endfunction

	// configuration
	logic [NUM_IN-1:0] en_q;
	logic [PTS_W-1:0] pts_q [NUM_IN];
	logic [WIN_W-1:0] win_q [NUM_IN];
	logic [READ_W-1:0] fs_q [NUM_IN];

	// filter state
	logic [FILT_W-1:0] filt_q [NUM_IN];
	logic [READ_W-1:0] shown_q [NUM_IN];
	logic [NUM_IN-1:0] primed_q;
	filt_state_e state_q;
	logic chan_q;
	logic [READ_W-1:0] raw_q;
	logic neg_q;

	// fifo and divider links
	logic fifo_valid;
	logic fifo_ready;
	logic [FIFO_W-1:0] fifo_data;
	logic div_start;
	logic div_done;
	logic [FILT_W-1:0] div_quo;

	// datapath terms
	logic [FILT_W:0] diff;
	logic [FILT_W-1:0] mag;
	logic [READ_W-1:0] err;
	logic [31:0] err_scaled;
	logic [31:0] limit_scaled;
	logic out_window;
	logic [FILT_W-1:0] filt_next;

	// register access
	logic wr_acc;
	logic [31:0] rd_word;
	logic rd_bad;

	reading_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.in_data({rd_chan, rd_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// more points divide the step further: stronger smoothing, slower response
	point_divider u_div (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(div_start),
		.dividend(mag),
		.divisor(pts_q[chan_q]), // RQ4
		.done(div_done),
		.quotient(div_quo)
	);

	// a new reading is taken only while idle, so none is dropped
	assign fifo_ready = (state_q == ST_IDLE); // RQ1

	assign diff = {1'b0, raw_q, FRAC_ZERO} - {1'b0, filt_q[chan_q]};
	assign mag = diff[FILT_W] ? FILT_W'(-diff) : diff[FILT_W-1:0];

	// window test without division: err*100 > full_scale*percent
	assign err = abs_sub(raw_q, filt_q[chan_q][FILT_W-1:FRAC_W]);
	assign err_scaled = 32'(err) * PCT_SCALE; // RQ7
	assign limit_scaled = 32'(fs_q[chan_q]) * 32'(win_q[chan_q]); // RQ7
	assign out_window = err_scaled > limit_scaled; // RQ6

	// weight 1/N applied toward the new reading
	assign filt_next = neg_q ? filt_q[chan_q] - div_quo : filt_q[chan_q] + div_quo; // RQ10

	// the divider runs only for a primed, enabled input whose reading is inside the window
	assign div_start = (state_q == ST_CHECK) && en_q[chan_q] && primed_q[chan_q] && !out_window;

	// sequencing of one reading
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_IDLE;
			chan_q <= 1'b0;
			raw_q <= '0;
			neg_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (fifo_valid)
					begin
						chan_q <= fifo_data[FIFO_W-1];
						raw_q <= fifo_data[READ_W-1:0];
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK:
				begin
					neg_q <= diff[FILT_W];
					state_q <= div_start ? ST_DIVIDE : ST_IDLE;
				end
				ST_DIVIDE:
				begin
					if (div_done)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// filtered value and restart tracking per input
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NUM_IN; i++)
				filt_q[i] <= '0;
			primed_q <= '0;
		end
		else
		begin
			// a disabled input forgets its history, so enabling it again restarts it
			for (int i = 0; i < NUM_IN; i++)
			begin
				if (!en_q[i])
					primed_q[i] <= 1'b0; // RQ8
			end
			if (state_q == ST_CHECK && en_q[chan_q] && (!primed_q[chan_q] || out_window))
			begin
				filt_q[chan_q] <= {raw_q, FRAC_ZERO}; // RQ9
				primed_q[chan_q] <= 1'b1;
			end
			else if (state_q == ST_DIVIDE && div_done)
			begin
				filt_q[chan_q] <= filt_next; // RQ2
			end
		end
	end

	// raw readings go to the control side as soon as taken
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_valid <= 1'b0;
			ctrl_chan <= 1'b0;
			ctrl_data <= '0;
		end
		else
		begin
			// control loops always act on the unfiltered reading
			ctrl_valid <= fifo_valid && fifo_ready; // RQ3
			if (fifo_valid && fifo_ready)
			begin
				ctrl_chan <= fifo_data[FIFO_W-1];
				ctrl_data <= fifo_data[READ_W-1:0]; // RQ3
			end
		end
	end

	// display side: exactly one value per reading
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			disp_valid <= 1'b0;
			disp_chan <= 1'b0;
			disp_data <= '0;
			disp_restart <= 1'b0;
			for (int i = 0; i < NUM_IN; i++)
				shown_q[i] <= '0;
		end
		else
		begin
			disp_valid <= 1'b0;
			disp_restart <= 1'b0;
			if (state_q == ST_CHECK && !div_start)
			begin
				// disabled input, first reading or window restart: show raw
				disp_valid <= 1'b1; // RQ2
				disp_chan <= chan_q;
				disp_data <= raw_q; // RQ8
				disp_restart <= en_q[chan_q]; // RQ6
				shown_q[chan_q] <= raw_q;
			end
			else if (state_q == ST_DIVIDE && div_done)
			begin
				disp_valid <= 1'b1; // RQ1
				disp_chan <= chan_q;
				// integer part only; the fraction stays inside the filter
				disp_data <= filt_next[FILT_W-1:FRAC_W]; // RQ3
				shown_q[chan_q] <= filt_next[FILT_W-1:FRAC_W];
			end
		end
	end

	// apb slave: read data and error are latched in the setup cycle
	assign wr_acc = psel && penable && pready && pwrite;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_bad = 1'b0;
		unique case (paddr)
			OFS_CTRL: rd_word = 32'(en_q);
			OFS_PTS_A: rd_word = 32'(pts_q[0]);
			OFS_PTS_B: rd_word = 32'(pts_q[1]);
			OFS_WIN_A: rd_word = 32'(win_q[0]);
			OFS_WIN_B: rd_word = 32'(win_q[1]);
			OFS_FS_A: rd_word = 32'(fs_q[0]);
			OFS_FS_B: rd_word = 32'(fs_q[1]);
			OFS_DISP_A: rd_word = 32'(shown_q[0]);
			OFS_DISP_B: rd_word = 32'(shown_q[1]);
			OFS_STATUS:
			begin
				rd_word[BIT_ST_BUSY] = (state_q != ST_IDLE) || fifo_valid;
				rd_word[BIT_ST_PRIMED_A] = primed_q[0];
				rd_word[BIT_ST_PRIMED_B] = primed_q[1];
			end
			default: rd_bad = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && !penable;
			// the error flag stands with pready only, never past the access cycle
			pslverr <= psel && !penable && rd_bad;
			if (psel && !penable)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
			end
		end
	end

	// configuration registers; out-of-range writes are clamped
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			en_q <= '0;
			for (int i = 0; i < NUM_IN; i++)
			begin
				pts_q[i] <= PTS_DEF[PTS_W-1:0]; // RQ5
				win_q[i] <= WIN_DEF[WIN_W-1:0]; // RQ7
				fs_q[i] <= FS_DEF;
			end
		end
		else if (wr_acc)
		begin
			unique case (paddr)
				OFS_CTRL:
				begin
					en_q[0] <= pwdata[BIT_EN_A]; // RQ8
					en_q[1] <= pwdata[BIT_EN_B]; // RQ8
				end
				OFS_PTS_A: pts_q[0] <= PTS_W'(clamp(pwdata, PTS_MIN, PTS_MAX)); // RQ5
				OFS_PTS_B: pts_q[1] <= PTS_W'(clamp(pwdata, PTS_MIN, PTS_MAX)); // RQ5
				OFS_WIN_A: win_q[0] <= WIN_W'(clamp(pwdata, WIN_MIN, WIN_MAX)); // RQ7
				OFS_WIN_B: win_q[1] <= WIN_W'(clamp(pwdata, WIN_MIN, WIN_MAX)); // RQ7
				OFS_FS_A: fs_q[0] <= pwdata[READ_W-1:0];
				OFS_FS_B: fs_q[1] <= pwdata[READ_W-1:0];
				default:
				begin
				end
			endcase
		end
	end

endmodule

// ### sim/reading_smoothing_filter_props.sv
// Purpose: port assertions for the reading smoothing filter
// Assumes: zero-wait APB, one reading in the engine at a time
// Notes: bound to every filter instance
`timescale 1ns/1ps
module reading_smoothing_filter_props
(
	input logic sys_clk,
	input logic reset_n,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic rd_valid,
	input logic rd_ready,
	input logic ctrl_valid,
	input logic ctrl_chan,
	input logic [23:0] ctrl_data,
	input logic disp_valid,
	input logic disp_chan,
	input logic [23:0] disp_data,
	input logic disp_restart
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [1:0] pend_q;
	// readings passed to control but not yet displayed
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			pend_q <= 2'h0;
		else
			pend_q <= pend_q + {1'b0, ctrl_valid} - {1'b0, disp_valid};
	end
	a_pready_access: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_ctrl_follows: assert property (rd_valid && rd_ready |-> ##[1:400] ctrl_valid)
		else $error("taken reading never reached control");
	a_disp_follows: assert property (ctrl_valid |-> ##[1:40] disp_valid)
		else $error("no display update for reading");
	a_no_skip: assert property (ctrl_valid |-> pend_q == 2'h0 || disp_valid)
		else $error("reading left without display");
	a_disp_paired: assert property (disp_valid |-> pend_q == 2'h1)
		else $error("display without reading");
	a_restart_disp: assert property (disp_restart |-> disp_valid)
		else $error("restart flag outside display pulse");
	a_restart_raw: assert property (disp_restart && !ctrl_valid |-> disp_data == ctrl_data)
		else $error("restart did not load raw reading");
	a_disp_chan: assert property (disp_valid && !ctrl_valid |-> disp_chan == ctrl_chan)
		else $error("display channel differs");
	cover property (disp_restart);
	cover property (pslverr);
	cover property (rd_valid && !rd_ready);
endmodule

bind reading_smoothing_filter reading_smoothing_filter_props u_props (.sys_clk, .reset_n, .psel,
	.penable, .pready, .pslverr, .rd_valid, .rd_ready, .ctrl_valid, .ctrl_chan, .ctrl_data,
	.disp_valid, .disp_chan, .disp_data, .disp_restart);

// ### sim/reading_source.sv
// Purpose: sensor front end model offering readings
// Assumes: a reading is held until the block takes it
// Notes: idle data lines show the inverse of the last value
`timescale 1ns/1ps
module reading_source
	import filter_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rd_ready,
	output logic rd_valid,
	output logic rd_chan,
	output logic [READ_W-1:0] rd_data
);
	initial
	begin
		rd_valid = 1'b0;
		rd_chan = 1'b0;
		rd_data = '0;
	end
	task automatic send(input logic c, input logic [READ_W-1:0] d, input int gap);
		int k;
		repeat (gap + 1) @(posedge sys_clk);
		rd_valid <= 1'b1;
		rd_chan <= c;
		rd_data <= d;
		k = 0;
		@(posedge sys_clk);
		while (rd_ready !== 1'b1 && k < 2000)
		begin
			@(posedge sys_clk);
			k++;
		end
		rd_valid <= 1'b0;
		rd_chan <= ~c;
		rd_data <= ~d;
	endtask
endmodule

// ### sim/reading_smoothing_filter_test.sv
// Purpose: self-checking bench for the reading smoothing filter
// Assumes: expected values come from a bench-side filter model
// Notes: a monitor compares every control and display pulse
`timescale 1ns/1ps
module reading_smoothing_filter_test;
	import filter_pkg::*;
	logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, full_seen;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rd_valid, rd_chan, rd_ready, ctrl_valid, ctrl_chan, disp_valid, disp_chan, disp_restart;
	logic [READ_W-1:0] rd_data, ctrl_data, disp_data;
	int mismatches, n_compared;
	logic [READ_W:0] raw_q[$];
	logic [READ_W:0] dsp_q[$];
	logic rst_q[$];
	logic en[2];
	logic primed[2];
	longint filt[2], npts[2], fs[2], pct[2];
	reading_smoothing_filter dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rd_valid, .rd_chan, .rd_data, .rd_ready, .ctrl_valid,
		.ctrl_chan, .ctrl_data, .disp_valid, .disp_chan, .disp_data, .disp_restart);
	reading_source src (.sys_clk, .rd_ready, .rd_valid, .rd_chan, .rd_data);
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic lim(input int k, input int n);
		if (k >= n)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t timeout", $time);
			finish_test();
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		@(posedge sys_clk);
		while (pready !== 1'b1 && k < 50)
		begin
			@(posedge sys_clk);
			k++;
		end
		lim(k, 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, 32'h0);
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic ex);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, ex});
	endtask
	// bench-side filter model, then the reading goes out
	task automatic put(input logic c, input longint d, input int gap);
		longint df;
		df = d - (filt[c] >>> 8);
		if (df < 0)
			df = -df;
		raw_q.push_back({c, READ_W'(d)});
		if (!en[c])
		begin
			primed[c] = 1'b0;
			dsp_q.push_back({c, READ_W'(d)});
			rst_q.push_back(1'b0);
		end
		else if (!primed[c] || df * 100 > fs[c] * pct[c])
		begin
			filt[c] = d <<< 8;
			primed[c] = 1'b1;
			dsp_q.push_back({c, READ_W'(d)});
			rst_q.push_back(1'b1);
		end
		else
		begin
			filt[c] = filt[c] + ((d <<< 8) - filt[c]) / npts[c];
			dsp_q.push_back({c, READ_W'(filt[c] >>> 8)});
			rst_q.push_back(1'b0);
		end
		src.send(c, READ_W'(d), gap);
	endtask
	task automatic drain();
		int k;
		k = 0;
		while ((dsp_q.size() > 0 || raw_q.size() > 0) && k < 3000)
		begin
			@(posedge sys_clk);
			k++;
		end
		lim(k, 3000);
	endtask
	always @(posedge sys_clk)
	begin
		if (ctrl_valid === 1'b1)
			chk({7'h0, ctrl_chan, ctrl_data}, raw_q.size() ? {7'h0, raw_q.pop_front()} : 32'hx);
		if (disp_valid === 1'b1)
		begin
			chk({7'h0, disp_chan, disp_data}, dsp_q.size() ? {7'h0, dsp_q.pop_front()} : 32'hx);
			chk({31'h0, disp_restart}, rst_q.size() ? {31'h0, rst_q.pop_front()} : 32'hx);
		end
		if (rd_valid === 1'b1 && rd_ready === 1'b0)
			full_seen = 1'b1;
	end
	task automatic t_regs();
		rdc(OFS_CTRL, 32'h0, 1'b0);
		rdc(OFS_PTS_B, 32'h08, 1'b0);
		rdc(OFS_WIN_A, 32'h01, 1'b0);
		rdc(8'h3c, 32'h0, 1'b1);
		wr(OFS_PTS_A, 32'h01);
		rdc(OFS_PTS_A, 32'h02, 1'b0);
		wr(OFS_PTS_A, 32'h41);
		rdc(OFS_PTS_A, 32'h40, 1'b0);
		wr(OFS_WIN_B, 32'h00);
		rdc(OFS_WIN_B, 32'h01, 1'b0);
		wr(OFS_WIN_B, 32'h0b);
		rdc(OFS_WIN_B, 32'h0a, 1'b0);
		wr(OFS_WIN_B, 32'h01);
	endtask
	task automatic t_raw();
		put(1'b0, 100, 0);
		put(1'b1, 200, 3);
		put(1'b0, 300, 0);
		drain();
		rdc(OFS_DISP_B, 32'd200, 1'b0);
	endtask
	task automatic t_smooth();
		wr(OFS_PTS_A, 32'h04);
		npts[0] = 4;
		en[0] = 1'b1;
		wr(OFS_CTRL, 32'h1);
		put(1'b0, 1000, 0);
		put(1'b0, 1100, 2);
		put(1'b1, 7, 0);
		put(1'b0, 1100, 0);
		drain();
		rdc(OFS_DISP_A, 32'(filt[0] >>> 8), 1'b0);
	endtask
	task automatic t_window();
		wr(OFS_FS_A, 32'd1000);
		wr(OFS_WIN_A, 32'h0a);
		rdc(OFS_FS_A, 32'd1000, 1'b0);
		fs[0] = 1000;
		pct[0] = 10;
		put(1'b0, (filt[0] >>> 8) + 100, 0);
		put(1'b0, (filt[0] >>> 8) + 101, 0);
		put(1'b0, (filt[0] >>> 8) - 101, 0);
		drain();
	endtask
	task automatic t_burst();
		wr(OFS_PTS_A, 32'h40);
		npts[0] = 64;
		full_seen = 1'b0;
		for (int i = 0; i < 14; i++)
			put(1'b0, 900 + i * 7, 0);
		drain();
		chk({31'h0, full_seen}, 32'h1);
		chk({31'h0, rd_ready}, 32'h1);
		wr(OFS_CTRL, 32'h0);
		en[0] = 1'b0;
		primed[0] = 1'b0;
		rdc(OFS_STATUS, 32'h0, 1'b0);
		wr(OFS_CTRL, 32'h1);
		en[0] = 1'b1;
		put(1'b0, 950, 0);
		drain();
		rdc(OFS_STATUS, 32'h2, 1'b0);
	endtask
	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		mismatches = 0;
		n_compared = 0;
		full_seen = 1'b0;
		en = '{1'b0, 1'b0};
		primed = '{1'b0, 1'b0};
		filt = '{0, 0};
		npts = '{8, 8};
		fs = '{24'hff_ffff, 24'hff_ffff};
		pct = '{1, 1};
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_regs();
		t_raw();
		t_smooth();
		t_window();
		t_burst();
		finish_test();
	end
endmodule
